// File: hdl/psoc_top.sv
// Contract
// RQ1: Step-down and controller supply on in normal, sleep
// RQ2: Step-up only when needed and pin-selected
// RQ3: Core supply follows pin sampled at sequencing
// RQ4: Normal: standby, comm, reference switchable by software
// RQ5: Normal: trackers switchable independently
// RQ6: Normal: wake-up timer off
// RQ7: Normal: watchdogs, error monitor switchable
// RQ8: Reset output high in normal and sleep
// RQ9: Safe outputs high only in normal
// RQ10: Standby: regulators, reference, trackers off
// RQ11: Standby: standby regulator per stored bit
// RQ12: Standby, sleep: wake timer per configuration
// RQ13: Standby: watchdogs and error monitor off
// RQ14: Standby: reset and safe outputs low
// RQ15: Sleep keeps prior standby regulator setting
// RQ16: Sleep: overcurrent raises interrupt, goes wake
// RQ17: Sleep enables frozen from transition request
// RQ18: Sleep: watchdogs per sleep configuration
// RQ19: Sleep: error monitor per sleep configuration
// RQ20: Sleep: safe outputs held low
// RQ21: Wake input or command leaves sleep
// RQ22: Outputs registered, change on state or write
//
// Purpose: State and configuration control of supply enables
// Assumes: Register port, reads return data one cycle later
// Notes: Sequencing strobe latches core select pin
//
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/1ns
module psoc_top (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic step_up_select_pin_i,
    input wire logic vin_low_i,
    input wire logic core_supply_select_pin_i,
    input wire logic sequencing_i,
    input wire logic uc_overcurrent_i,
    input wire logic enable_wake_input_i,
    input wire logic wake_input_i,
    output logic irq_o,
    output logic stepdown_en_o,
    output logic stepup_en_o,
    output logic uc_reg_en_o,
    output logic stby_reg_en_o,
    output logic com_reg_en_o,
    output logic core_en_o,
    output logic vref_en_o,
    output logic trk1_en_o,
    output logic trk2_en_o,
    output logic wake_timer_en_o,
    output logic wdog_en_o,
    output logic errm_en_o,
    output logic reset_o,
    output logic safe_state_out_a_o,
    output logic safe_state_out_b_o
);
    typedef struct packed {
        psoc_pkg::psoc_state_t state;
        logic [7:0] norm_cfg;
        logic [7:0] sleep_cfg;
        logic core_sel;
        logic irq;
        logic [7:0] rdata;
    } psoc_top_st_t;
    psoc_top_st_t st_r;
    psoc_top_st_t st_nxt;
    psoc_dec_if dif ();
    logic cmd_wr;
    logic wake_evt;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
        return a == off;
    endfunction

    assign cmd_wr = wr_i && hit(addr_i, psoc_pkg::REG_CMD);
    assign wake_evt = enable_wake_input_i || wake_input_i || uc_overcurrent_i
        || (cmd_wr && wdata_i[psoc_pkg::C_WAKE]);

    always_comb begin
        st_nxt = st_r;
        st_nxt.rdata = 8'h00;
        if (sequencing_i) begin
            st_nxt.core_sel = core_supply_select_pin_i; // [RQ3]
        end
        // Configuration writes only land outside sleep, freezing sleep enables
        if (wr_i && st_r.state != psoc_pkg::ST_SLEEP) begin
            if (hit(addr_i, psoc_pkg::REG_NORM_CFG)) begin
                st_nxt.norm_cfg = wdata_i; // [RQ4] [RQ5] [RQ7]
            end
            if (hit(addr_i, psoc_pkg::REG_SLEEP_CFG)) begin
                st_nxt.sleep_cfg = wdata_i; // [RQ17]
            end
        end
        if (cmd_wr && wdata_i[psoc_pkg::C_IRQ_CLR]) begin
            st_nxt.irq = 1'b0;
        end
        unique case (st_r.state)
            psoc_pkg::ST_NORMAL, psoc_pkg::ST_WAKE: begin
                if (cmd_wr && wdata_i[psoc_pkg::C_SLEEP]) begin
                    st_nxt.state = psoc_pkg::ST_SLEEP;
                end else if (cmd_wr && wdata_i[psoc_pkg::C_STANDBY]) begin
                    st_nxt.state = psoc_pkg::ST_STANDBY;
                end else if (cmd_wr && wdata_i[psoc_pkg::C_NORMAL]) begin
                    st_nxt.state = psoc_pkg::ST_NORMAL;
                end
            end
            psoc_pkg::ST_STANDBY: begin
                // Leaving standby passes through power sequencing outside this block
                if (cmd_wr && wdata_i[psoc_pkg::C_NORMAL]) begin
                    st_nxt.state = psoc_pkg::ST_NORMAL;
                end
            end
            psoc_pkg::ST_SLEEP: begin
                if (wake_evt) begin
                    st_nxt.state = psoc_pkg::ST_WAKE; // [RQ16] [RQ21]
                end
                if (uc_overcurrent_i) begin
                    st_nxt.irq = 1'b1; // [RQ16]
                end
            end
        endcase
        if (rd_i) begin
            unique case (addr_i)
                psoc_pkg::REG_STATE: st_nxt.rdata = {6'h00, st_r.state};
                psoc_pkg::REG_NORM_CFG: st_nxt.rdata = st_r.norm_cfg;
                psoc_pkg::REG_SLEEP_CFG: st_nxt.rdata = st_r.sleep_cfg;
                psoc_pkg::REG_STATUS: st_nxt.rdata = {6'h00, st_r.core_sel, st_r.irq};
                psoc_pkg::REG_OUTPUTS: st_nxt.rdata = {dif.outs.reset_hi, dif.outs.ss_a,
                    dif.outs.uc_reg_en, dif.outs.stby_en, dif.outs.com_en,
                    dif.outs.vref_en, dif.outs.wdog_en, dif.outs.errm_en};
                default: st_nxt.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            st_r.state <= psoc_pkg::ST_NORMAL;
            st_r.norm_cfg <= psoc_pkg::NORM_CFG_RST;
            st_r.sleep_cfg <= psoc_pkg::SLEEP_CFG_RST;
            st_r.core_sel <= 1'b0;
            st_r.irq <= 1'b0;
            st_r.rdata <= 8'h00;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign dif.state = st_r.state;
    assign dif.norm_cfg = st_r.norm_cfg;
    assign dif.sleep_cfg = st_r.sleep_cfg;
    assign dif.stepup_need = step_up_select_pin_i && vin_low_i; // [RQ2]
    assign dif.core_sel = st_r.core_sel;

    psoc_decode u_dec (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .d(dif)
    );

    assign rdata_o = st_r.rdata;
    assign irq_o = st_r.irq;
    assign stepdown_en_o = dif.outs.stepdown_en;
    assign stepup_en_o = dif.outs.stepup_en;
    assign uc_reg_en_o = dif.outs.uc_reg_en;
    assign stby_reg_en_o = dif.outs.stby_en;
    assign com_reg_en_o = dif.outs.com_en;
    assign core_en_o = dif.outs.core_en;
    assign vref_en_o = dif.outs.vref_en;
    assign trk1_en_o = dif.outs.trk1_en;
    assign trk2_en_o = dif.outs.trk2_en;
    assign wake_timer_en_o = dif.outs.wkt_en;
    assign wdog_en_o = dif.outs.wdog_en;
    assign errm_en_o = dif.outs.errm_en;
    assign reset_o = dif.outs.reset_hi;
    assign safe_state_out_a_o = dif.outs.ss_a;
    assign safe_state_out_b_o = dif.outs.ss_b;

    // Decoder output lags reset release by one edge
    normal_on_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        $past(rst_n_i) && $past(st_r.state) == psoc_pkg::ST_NORMAL
        |-> stepdown_en_o && uc_reg_en_o)
        else $error("Supply off in normal"); // [RQ1]
    stepup_gate_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        stepup_en_o |-> $past(step_up_select_pin_i) && $past(vin_low_i))
        else $error("Step-up without need"); // [RQ2]
    wkt_normal_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        $past(st_r.state) == psoc_pkg::ST_NORMAL |-> !wake_timer_en_o)
        else $error("Wake timer on in normal"); // [RQ6]
    reset_high_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        $past(st_r.state) == psoc_pkg::ST_SLEEP |-> reset_o)
        else $error("Reset low in sleep"); // [RQ8]
    safe_rel_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        safe_state_out_a_o || safe_state_out_b_o |-> $past(st_r.state) == psoc_pkg::ST_NORMAL)
        else $error("Safe state released outside normal"); // [RQ9]
    standby_rst_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        $past(st_r.state) == psoc_pkg::ST_STANDBY |-> !reset_o && !safe_state_out_b_o)
        else $error("Reset or safe high in standby"); // [RQ14]
    ovc_wake_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        st_r.state == psoc_pkg::ST_SLEEP && uc_overcurrent_i
        |=> st_r.state == psoc_pkg::ST_WAKE && irq_o)
        else $error("Overcurrent did not wake"); // [RQ16]
    sleep_frozen_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        st_r.state == psoc_pkg::ST_SLEEP && $past(st_r.state) == psoc_pkg::ST_SLEEP
        |-> $stable(st_r.sleep_cfg) && $stable(st_r.norm_cfg))
        else $error("Configuration changed in sleep"); // [RQ17]
    sleep_wdog_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        $past(st_r.state) == psoc_pkg::ST_SLEEP
        |-> wdog_en_o == $past(st_r.sleep_cfg[psoc_pkg::S_WDOG])
        && errm_en_o == $past(st_r.sleep_cfg[psoc_pkg::S_ERRM]))
        else $error("Sleep supervision mismatch"); // [RQ18] [RQ19]
    wake_in_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        st_r.state == psoc_pkg::ST_SLEEP && (wake_input_i || enable_wake_input_i)
        |=> st_r.state == psoc_pkg::ST_WAKE)
        else $error("Wake input ignored"); // [RQ21]
endmodule // psoc_top

// File: hdl/psoc_pkg.sv
// Purpose: Constants and types for the power state output control block
// Assumes: Register port with one-cycle read latency, 8-bit data
// Notes: Offsets are word indices on a plain register port
package psoc_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam logic [3:0] REG_STATE = 4'h0;
    localparam logic [3:0] REG_NORM_CFG = 4'h1;
    localparam logic [3:0] REG_SLEEP_CFG = 4'h2;
    localparam logic [3:0] REG_CMD = 4'h3;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_OUTPUTS = 4'h5;
    // Normal configuration bit positions
    localparam int B_STBY = 0;
    localparam int B_COM = 1;
    localparam int B_VREF = 2;
    localparam int B_TRK1 = 3;
    localparam int B_TRK2 = 4;
    localparam int B_WDOG = 5;
    localparam int B_ERRM = 6;
    localparam int B_WKT = 7;
    // Sleep configuration bit positions
    localparam int S_COM = 0;
    localparam int S_VREF = 1;
    localparam int S_TRK1 = 2;
    localparam int S_TRK2 = 3;
    localparam int S_WDOG = 4;
    localparam int S_ERRM = 5;
    // Command bits
    localparam int C_NORMAL = 0;
    localparam int C_STANDBY = 1;
    localparam int C_SLEEP = 2;
    localparam int C_WAKE = 3;
    localparam int C_IRQ_CLR = 4;
    localparam logic [7:0] NORM_CFG_RST = 8'h6f;
    localparam logic [7:0] SLEEP_CFG_RST = 8'h00;
    typedef enum logic [1:0] {
        ST_NORMAL,
        ST_STANDBY,
        ST_SLEEP,
        ST_WAKE
    } psoc_state_t;
    typedef struct packed {
        logic stepdown_en;
        logic stepup_en;
        logic uc_reg_en;
        logic stby_en;
        logic com_en;
        logic core_en;
        logic vref_en;
        logic trk1_en;
        logic trk2_en;
        logic wkt_en;
        logic wdog_en;
        logic errm_en;
        logic reset_hi;
        logic ss_a;
        logic ss_b;
    } psoc_out_t;
endpackage

// File: hdl/psoc_dec_if.sv
// Purpose: Carries state and configuration to the output decoder
// Assumes: One clock domain
// Notes: Decoder result flows back registered
`timescale 1ns/1ns
interface psoc_dec_if;
    psoc_pkg::psoc_state_t state;
    logic [7:0] norm_cfg;
    logic [7:0] sleep_cfg;
    logic stepup_need;
    logic core_sel;
    psoc_pkg::psoc_out_t outs;
    modport ctrl (output state, output norm_cfg, output sleep_cfg, output stepup_need,
        output core_sel, input outs);
    modport dec (input state, input norm_cfg, input sleep_cfg, input stepup_need,
        input core_sel, output outs);
endinterface

// File: hdl/psoc_decode.sv
// Purpose: Registered decode of enables from state and configuration
// Assumes: Inputs change on state change, configuration write, sequencing or stepup_need change
// Notes: Outputs lag the cause by one cycle
`timescale 1ns/1ns
module psoc_decode (
    input wire logic clock_i,
    input wire logic rst_n_i,
    psoc_dec_if.dec d
);
    typedef struct packed {
        psoc_pkg::psoc_out_t outs;
    } psoc_dec_st_t;
    psoc_dec_st_t st_r;
    psoc_dec_st_t st_nxt;

    function automatic psoc_pkg::psoc_out_t psoc_map(input psoc_pkg::psoc_state_t s,
        input logic [7:0] nc, input logic [7:0] sc, input logic up, input logic core);
        psoc_pkg::psoc_out_t o;
        o = '0;
        unique case (s)
            psoc_pkg::ST_NORMAL, psoc_pkg::ST_WAKE: begin
                o.stepdown_en = 1'b1; // [RQ1]
                o.uc_reg_en = 1'b1; // [RQ1]
                o.stepup_en = up; // [RQ2]
                o.core_en = core; // [RQ3]
                o.stby_en = nc[psoc_pkg::B_STBY]; // [RQ4]
                o.com_en = nc[psoc_pkg::B_COM]; // [RQ4]
                o.vref_en = nc[psoc_pkg::B_VREF]; // [RQ4]
                o.trk1_en = nc[psoc_pkg::B_TRK1]; // [RQ5]
                o.trk2_en = nc[psoc_pkg::B_TRK2]; // [RQ5]
                o.wkt_en = 1'b0; // [RQ6]
                o.wdog_en = nc[psoc_pkg::B_WDOG]; // [RQ7]
                o.errm_en = nc[psoc_pkg::B_ERRM]; // [RQ7]
                o.reset_hi = 1'b1; // [RQ8]
                // Wake keeps safe state low; only normal releases it
                o.ss_a = (s == psoc_pkg::ST_NORMAL); // [RQ9]
                o.ss_b = (s == psoc_pkg::ST_NORMAL); // [RQ9]
            end
            psoc_pkg::ST_STANDBY: begin
                // All supplies, supervision and safe outputs default off [RQ10] [RQ13] [RQ14]
                o.stby_en = nc[psoc_pkg::B_STBY]; // [RQ11]
                o.wkt_en = nc[psoc_pkg::B_WKT]; // [RQ12]
            end
            psoc_pkg::ST_SLEEP: begin
                o.stepdown_en = 1'b1; // [RQ1]
                o.uc_reg_en = 1'b1; // [RQ1]
                o.stepup_en = up; // [RQ2]
                o.core_en = core; // [RQ3]
                o.reset_hi = 1'b1; // [RQ8]
                o.stby_en = nc[psoc_pkg::B_STBY]; // [RQ15]
                o.wkt_en = nc[psoc_pkg::B_WKT]; // [RQ12]
                o.com_en = sc[psoc_pkg::S_COM]; // [RQ17]
                o.vref_en = sc[psoc_pkg::S_VREF]; // [RQ17]
                o.trk1_en = sc[psoc_pkg::S_TRK1]; // [RQ17]
                o.trk2_en = sc[psoc_pkg::S_TRK2]; // [RQ17]
                o.wdog_en = sc[psoc_pkg::S_WDOG]; // [RQ18]
                o.errm_en = sc[psoc_pkg::S_ERRM]; // [RQ19]
                o.ss_a = 1'b0; // [RQ20]
                o.ss_b = 1'b0; // [RQ20]
            end
        endcase
        return o;
    endfunction

    always_comb begin
        st_nxt.outs = psoc_map(d.state, d.norm_cfg, d.sleep_cfg, d.stepup_need, d.core_sel);
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt; // [RQ22]
        end
    end

    assign d.outs = st_r.outs;

    standby_off_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        $past(d.state) == psoc_pkg::ST_STANDBY |-> !d.outs.uc_reg_en && !d.outs.stepdown_en
        && !d.outs.com_en && !d.outs.vref_en && !d.outs.core_en && !d.outs.stepup_en
        && !d.outs.trk1_en && !d.outs.trk2_en)
        else $error("Supply on in standby"); // [RQ10]
    standby_sup_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        $past(d.state) == psoc_pkg::ST_STANDBY |-> !d.outs.wdog_en && !d.outs.errm_en)
        else $error("Supervision on in standby"); // [RQ13]
endmodule // psoc_decode

// File: verif/psoc_uc_model.sv
// Purpose: Controller-side model that drives the register port and its own load
// Assumes: One-cycle strobes; read data stands only in the cycle after the read strobe
// Notes: Address and data are inverted when idle so stale values are never read as valid
`timescale 1ns/1ns
module psoc_uc_model (
    input wire logic clock_i,
    input wire logic [7:0] rdata_i,
    output logic [3:0] addr_o,
    output logic [7:0] wdata_o,
    output logic wr_o,
    output logic rd_o,
    output logic overcurrent_o
);
    initial begin
        addr_o = 4'h0;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
        overcurrent_o = 1'b0;
    end

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clock_i);
        wr_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clock_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clock_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
        #1;
        d = rdata_i;
    endtask

    // Load step above threshold for one cycle
    task automatic load_spike();
        @(posedge clock_i);
        overcurrent_o <= 1'b1;
        @(posedge clock_i);
        overcurrent_o <= 1'b0;
    endtask
endmodule // psoc_uc_model

// File: verif/tb_top.sv
// Purpose: Self-checking bench for the power state output control block
// Assumes: Outputs settle within two cycles of a write or state change
// Notes: Random configurations with all-zero and all-one corners
`timescale 1ns/1ns
module tb_top;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic up_sel = 1'b0;
    logic vin_low = 1'b0;
    logic core_pin = 1'b0;
    logic seq = 1'b0;
    logic ena_wake = 1'b0;
    logic wake_input = 1'b0;
    logic irq;
    logic oc;
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    wire psoc_pkg::psoc_out_t o;
    logic [7:0] nc_m = 8'h6f;
    logic [7:0] sc_m = 8'h00;
    logic core_m = 1'b0;
    psoc_pkg::psoc_state_t st_m = psoc_pkg::ST_NORMAL;
    logic [7:0] v;
    logic [7:0] s;
    logic [7:0] d;
    int seed = 70;
    int error_cnt = 0;
    int samples_checked = 0;
    int i;
    int way;

    always #4 clock_i = ~clock_i;

    psoc_uc_model uc (.clock_i(clock_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
        .wr_o(wr), .rd_o(rd), .overcurrent_o(oc));

    psoc_top dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .step_up_select_pin_i(up_sel),
        .vin_low_i(vin_low), .core_supply_select_pin_i(core_pin), .sequencing_i(seq),
        .uc_overcurrent_i(oc), .enable_wake_input_i(ena_wake), .wake_input_i(wake_input),
        .irq_o(irq), .stepdown_en_o(o.stepdown_en), .stepup_en_o(o.stepup_en),
        .uc_reg_en_o(o.uc_reg_en), .stby_reg_en_o(o.stby_en), .com_reg_en_o(o.com_en),
        .core_en_o(o.core_en), .vref_en_o(o.vref_en), .trk1_en_o(o.trk1_en),
        .trk2_en_o(o.trk2_en), .wake_timer_en_o(o.wkt_en), .wdog_en_o(o.wdog_en),
        .errm_en_o(o.errm_en), .reset_o(o.reset_hi), .safe_state_out_a_o(o.ss_a),
        .safe_state_out_b_o(o.ss_b));

    // Normal and wake follow the normal set, sleep the frozen sleep set
    function automatic logic pick(input int n, input int sb);
        if (st_m == psoc_pkg::ST_NORMAL || st_m == psoc_pkg::ST_WAKE) begin
            return nc_m[n];
        end
        return (st_m == psoc_pkg::ST_SLEEP) & sc_m[sb];
    endfunction

    function automatic psoc_pkg::psoc_out_t exp_out();
        psoc_pkg::psoc_out_t e;
        logic on;
        on = (st_m != psoc_pkg::ST_STANDBY);
        e.stepdown_en = on;
        e.stepup_en = on & up_sel & vin_low;
        e.uc_reg_en = on;
        e.stby_en = nc_m[psoc_pkg::B_STBY];
        e.com_en = pick(psoc_pkg::B_COM, psoc_pkg::S_COM);
        e.core_en = on & core_m;
        e.vref_en = pick(psoc_pkg::B_VREF, psoc_pkg::S_VREF);
        e.trk1_en = pick(psoc_pkg::B_TRK1, psoc_pkg::S_TRK1);
        e.trk2_en = pick(psoc_pkg::B_TRK2, psoc_pkg::S_TRK2);
        e.wkt_en = (st_m == psoc_pkg::ST_STANDBY || st_m == psoc_pkg::ST_SLEEP)
            & nc_m[psoc_pkg::B_WKT];
        e.wdog_en = pick(psoc_pkg::B_WDOG, psoc_pkg::S_WDOG);
        e.errm_en = pick(psoc_pkg::B_ERRM, psoc_pkg::S_ERRM);
        e.reset_hi = on;
        e.ss_a = (st_m == psoc_pkg::ST_NORMAL);
        e.ss_b = (st_m == psoc_pkg::ST_NORMAL);
        return e;
    endfunction

    // Outputs register layout, highest bit first
    function automatic logic [7:0] out_reg(input psoc_pkg::psoc_out_t e);
        return {e.reset_hi, e.ss_a, e.uc_reg_en, e.stby_en, e.com_en, e.vref_en, e.wdog_en,
            e.errm_en};
    endfunction

    task automatic print_verdict();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk_out();
        samples_checked++;
        if (o !== exp_out()) begin
            error_cnt++;
            $display("Error at %0t: outputs %h expected %h", $time, o, exp_out());
        end
    endtask

    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: %s read %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp, input string what);
        uc.rd_reg(a, d);
        chk_val(d, exp, what);
    endtask

    // Two cycles from cause to output, plus margin
    task automatic settle();
        repeat (3) @(posedge clock_i);
        #1;
    endtask

    initial begin
        repeat (50000) @(posedge clock_i);
        error_cnt++;
        $display("Error at %0t: run limit reached", $time);
        print_verdict();
    end

    initial begin
        repeat (20) @(posedge clock_i);
        rst_n_i <= 1'b1;
        settle();
        chk_out();
        rd_chk(psoc_pkg::REG_NORM_CFG, 8'h6f, "normal cfg");
        rd_chk(psoc_pkg::REG_SLEEP_CFG, 8'h00, "sleep cfg");
        rd_chk(4'hf, 8'h00, "unmapped");
        @(posedge clock_i);
        seq <= 1'b1;
        core_pin <= 1'b1;
        repeat (2) @(posedge clock_i);
        seq <= 1'b0;
        core_m = 1'b1;
        @(posedge clock_i);
        core_pin <= 1'b0;
        settle();
        chk_out();
        rd_chk(psoc_pkg::REG_STATUS, 8'h02, "status");
        for (i = 0; i < 24; i++) begin
            @(posedge clock_i);
            up_sel <= 1'($random(seed));
            vin_low <= 1'($random(seed));
            v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
            uc.wr_reg(psoc_pkg::REG_NORM_CFG, v);
            nc_m = v;
            settle();
            chk_out();
            rd_chk(psoc_pkg::REG_OUTPUTS, out_reg(exp_out()), "outputs");
            if (i % 3 == 0) begin
                uc.wr_reg(psoc_pkg::REG_CMD, 8'h02);
                st_m = psoc_pkg::ST_STANDBY;
                settle();
                chk_out();
                rd_chk(psoc_pkg::REG_STATE, 8'h01, "state");
                uc.wr_reg(psoc_pkg::REG_CMD, 8'h01);
                st_m = psoc_pkg::ST_NORMAL;
            end else if (i % 3 == 1) begin
                s = (i == 1) ? 8'h3f : 8'($random(seed)) & 8'h3f;
                uc.wr_reg(psoc_pkg::REG_SLEEP_CFG, s);
                sc_m = s;
                // Sleep bit set, lower command bits random to probe priority
                uc.wr_reg(psoc_pkg::REG_CMD, 8'h04 | (8'($random(seed)) & 8'h03));
                st_m = psoc_pkg::ST_SLEEP;
                settle();
                chk_out();
                uc.wr_reg(psoc_pkg::REG_NORM_CFG, ~v);
                uc.wr_reg(psoc_pkg::REG_SLEEP_CFG, ~s & 8'h3f);
                settle();
                chk_out();
                rd_chk(psoc_pkg::REG_OUTPUTS, out_reg(exp_out()), "sleep outputs");
                rd_chk(psoc_pkg::REG_STATE, 8'h02, "state");
                way = (i / 3) % 4;
                if (way == 0) begin
                    uc.load_spike();
                end else if (way == 3) begin
                    uc.wr_reg(psoc_pkg::REG_CMD, 8'h08);
                end else begin
                    @(posedge clock_i);
                    ena_wake <= (way == 1);
                    wake_input <= (way == 2);
                    @(posedge clock_i);
                    ena_wake <= 1'b0;
                    wake_input <= 1'b0;
                end
                st_m = psoc_pkg::ST_WAKE;
                settle();
                chk_out();
                chk_val({7'h00, irq}, {7'h00, way == 0}, "irq");
                rd_chk(psoc_pkg::REG_STATE, 8'h03, "state");
                uc.wr_reg(psoc_pkg::REG_CMD, 8'h11);
                st_m = psoc_pkg::ST_NORMAL;
                settle();
                chk_val({7'h00, irq}, 8'h00, "irq clear");
            end
        end
        // Reset taken from sleep must bring back every default
        uc.wr_reg(psoc_pkg::REG_SLEEP_CFG, 8'h3f);
        uc.wr_reg(psoc_pkg::REG_CMD, 8'h04);
        @(posedge clock_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1'b1;
        nc_m = psoc_pkg::NORM_CFG_RST;
        sc_m = psoc_pkg::SLEEP_CFG_RST;
        core_m = 1'b0;
        st_m = psoc_pkg::ST_NORMAL;
        settle();
        chk_out();
        rd_chk(psoc_pkg::REG_SLEEP_CFG, psoc_pkg::SLEEP_CFG_RST, "sleep cfg reset");
        rd_chk(psoc_pkg::REG_STATUS, 8'h00, "status reset");
        print_verdict();
    end
endmodule // tb_top
